// ---- hw/spd_post_div.sv ----
// Purpose: channel A post-divider, low-frequency clock and frame pulse
// Assumes: ref_clk is the synthesizer output clock; lf_tick is a
//   same-domain strobe at twice the synthesizer base frequency
// Notes: odd ratios give a high phase one count longer than the low one: a cycle in div, a tick in low-frequency mode
`timescale 1ns/1ps
module spd_post_div import spd_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register access, paged address
	input wire spd_req_t req,
	output logic [7:0] rdata_q,
	// timing sources
	input wire logic lf_tick,
	input wire logic [2:0] src_clk_pin,
	// output
	output logic out_q
);
`include "spd_defs.svh"

	spd_cfg_t cfg_q;
	spd_cfg_t act_q;
	spd_cfg_t act_d;
	logic [23:0] cnt_q;
	logic [23:0] cnt_d;
	logic p_q;
	logic p_d;
	logic sel_prev_q;
	logic sel_prev_d;
	logic out_d;
	logic [7:0] rdata_d;
	logic [2:0] src_lvl;
	logic [3:0] lvl_map;
	spd_mode_t mode_w;
	spd_mode_t mode_d;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			spd_src_sync u_sync (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.src_pin(src_clk_pin[gi]),
				.level_q(src_lvl[gi])
			);
		end
	endgenerate

	// register decode; the upper page is only reachable with page bit set
	wire wr_hi = req.wr && req.addr == `SPD_ADDR_HI;
	wire wr_mid = req.wr && req.addr == `SPD_ADDR_MID;
	wire wr_lo = req.wr && req.addr == `SPD_ADDR_LO;
	assign rdata_d = !req.rd ? rdata_q :
		req.addr == `SPD_ADDR_HI ? cfg_q[23:16] :
		req.addr == `SPD_ADDR_MID ? cfg_q[15:8] :
		req.addr == `SPD_ADDR_LO ? cfg_q[7:0] : 8'h00;

	// mode of the applied setting; in div all 24 bits, type bits included, are ratio bits
	assign mode_w = act_q.otype != `SPD_TYPE_SPECIAL ? SPD_MODE_DIV :
		act_q.src == `SPD_SRC_LOWFREQ ? SPD_MODE_LF :
		SPD_MODE_FRAME;
	assign mode_d = act_d.otype != `SPD_TYPE_SPECIAL ? SPD_MODE_DIV :
		act_d.src == `SPD_SRC_LOWFREQ ? SPD_MODE_LF : SPD_MODE_FRAME;

	// source 01 is B, 10 is C, 11 is D
	assign lvl_map = {src_lvl, 1'b0};
	wire sel_lvl = lvl_map[act_q.src];
	wire new_lvl = lvl_map[cfg_q.src];
	wire rise_w = sel_lvl & ~sel_prev_q;
	wire fall_w = ~sel_lvl & sel_prev_q;

	// period length in counted units
	wire [23:0] ratio_w = act_q;
	wire [23:0] rate_w = {8'h00, act_q.rate};
	wire [23:0] n_div = ratio_w < `SPD_MIN_RATIO ? `SPD_MIN_RATIO : ratio_w;
	wire [23:0] n_lf = rate_w < `SPD_MIN_RATIO ? `SPD_MIN_RATIO : rate_w;
	wire [23:0] n_frm = rate_w < `SPD_MIN_SPACING ? `SPD_MIN_SPACING :
		rate_w;
	wire [23:0] n_w = mode_w == SPD_MODE_DIV ? n_div :
		mode_w == SPD_MODE_LF ? n_lf : n_frm;
	wire [23:0] half_w = (n_w >> 1) + {23'h000000, n_w[0]};
	wire last_w = cnt_q == n_w - `SPD_MIN_SPACING;

	// counter advance: every cycle, every tick, or every source period
	wire adv_w = mode_w == SPD_MODE_DIV ? 1'b1 :
		mode_w == SPD_MODE_LF ? lf_tick : rise_w;

	// gci starts the pulse on the boundary edge; the midpoint style starts
	// it half a period earlier so the boundary lands in its middle
	wire frm_ev = act_q.style ? rise_w : fall_w;

	// a new setting waits for the end of a period or an idle pulse line,
	// so no cut-short clock phase or partial pulse ever reaches the pin
	wire pend_w = cfg_q != act_q;
	wire load_w = pend_w && (mode_w == SPD_MODE_FRAME ? !p_q :
		adv_w && last_w);

	assign act_d = load_w ? cfg_q : act_q;
	assign cnt_d = load_w ? 24'h000000 :
		adv_w ? (last_w ? 24'h000000 : cnt_q + 24'h000001) : cnt_q;
	// pulse spans one source period, edge to like edge, when the spacing is two or more
	assign p_d = load_w || mode_w != SPD_MODE_FRAME ? 1'b0 :
		frm_ev ? last_w : p_q;
	assign sel_prev_d = load_w ? new_lvl : sel_lvl;
	assign out_d = mode_d == SPD_MODE_FRAME ? p_d ^ act_d.pol :
		cnt_d < half_w;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= `SPD_CFG_RESET;
		end else begin
			if (wr_hi) cfg_q[23:16] <= req.wdata;
			if (wr_mid) cfg_q[15:8] <= req.wdata;
			if (wr_lo) cfg_q[7:0] <= req.wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			act_q <= `SPD_CFG_RESET;
			cnt_q <= 24'h000000;
			p_q <= 1'b0;
			sel_prev_q <= 1'b0;
			out_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			act_q <= act_d;
			cnt_q <= cnt_d;
			p_q <= p_d;
			sel_prev_q <= sel_prev_d;
			out_q <= out_d;
			rdata_q <= rdata_d;
		end
	end

	// helper: length of the current high phase
	logic [23:0] hi_len_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_len_q <= 24'h000000;
		end else begin
			hi_len_q <= out_q ? hi_len_q + 24'h000001 : 24'h000000;
		end
	end

	// pulse edges as seen on the registered pulse state
	sequence s_pulse_start;
		!p_q ##1 p_q;
	endsequence

	sequence s_pulse_end;
		p_q ##1 !p_q;
	endsequence

	a_div_high_len: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		$fell(out_q) && mode_w == SPD_MODE_DIV && $stable(act_q)
		&& !$past(load_w) |-> hi_len_q == half_w)
		else $error("divider high phase length wrong");

	// the count must climb to the whole register value, not the low half
	a_div_full_ratio: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		mode_w == SPD_MODE_DIV && ratio_w >= `SPD_MIN_RATIO && !load_w
		&& cnt_q != ratio_w - 24'h000001
		|=> cnt_q == $past(cnt_q) + 24'h000001)
		else $error("divider ignores upper ratio bits");

	a_lf_tick_only: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		mode_w == SPD_MODE_LF && !lf_tick && !load_w
		|=> $stable(cnt_q))
		else $error("low frequency count moved without tick");

	a_frame_spacing: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		mode_w == SPD_MODE_FRAME && rise_w && last_w && !load_w
		|=> cnt_q == 24'h000000)
		else $error("frame spacing count did not wrap");

	a_pulse_hold: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		mode_w == SPD_MODE_FRAME && p_q && !frm_ev && !load_w
		|=> p_q)
		else $error("pulse ended inside a source period");

	// a pulse may only end on the same kind of edge that started it
	a_pulse_drop: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		s_pulse_end |-> $past(frm_ev))
		else $error("pulse dropped off a source edge");

	a_src_pick_b: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		act_q.src == 2'h1 |-> sel_lvl == src_lvl[0])
		else $error("source 01 does not pick divider B");

	a_src_select: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		act_q.src == 2'h2 |-> sel_lvl == src_lvl[1])
		else $error("source 10 does not pick divider C");

	a_src_pick_d: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		act_q.src == 2'h3 |-> sel_lvl == src_lvl[2])
		else $error("source 11 does not pick divider D");

	a_pulse_polarity: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		mode_w == SPD_MODE_FRAME |-> out_q == (p_q ^ act_q.pol))
		else $error("pulse polarity wrong");

	a_pulse_style: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		s_pulse_start |-> $past(frm_ev))
		else $error("pulse started on the wrong source edge");

	// a clock setting may only land at the end of a low phase, and the
	// new period must then open at count zero with the output high
	a_apply_boundary: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		load_w && mode_w != SPD_MODE_FRAME
		|-> adv_w && last_w && !out_q
		##1 cnt_q == 24'h000000 && (out_q || mode_w == SPD_MODE_FRAME))
		else $error("setting applied mid period");

endmodule

// ---- hw/spd_defs.svh ----
// Purpose: constants for the channel A post-divider / frame pulse block
// Assumes: included by its bare name after the package
// Notes: byte offsets are the paged addresses, page bit already applied
`ifndef SPD_DEFS_SVH
`define SPD_DEFS_SVH

`define SPD_ADDR_HI 8'h80
`define SPD_ADDR_MID 8'h81
`define SPD_ADDR_LO 8'h82
`define SPD_CFG_RESET 24'h000002
`define SPD_TYPE_POS 20
`define SPD_STYLE_POS 19
`define SPD_POL_POS 18
`define SPD_SRC_POS 16
`define SPD_TYPE_SPECIAL 4'hf
`define SPD_SRC_LOWFREQ 2'h0
`define SPD_MIN_RATIO 24'h000002
`define SPD_MIN_SPACING 24'h000001
`define SPD_SYNC_RESET 3'h0

`endif

// ---- hw/spd_pkg.sv ----
// Purpose: types shared by the post-divider block
// Assumes: nothing
// Notes: cfg layout matches the 24-bit register bit for bit
package spd_pkg;

	typedef enum logic [1:0] {
		SPD_MODE_DIV = 2'b00,
		SPD_MODE_LF = 2'b01,
		SPD_MODE_FRAME = 2'b10
	} spd_mode_t;

	typedef struct packed {
		logic [3:0] otype;
		logic style;
		logic pol;
		logic [1:0] src;
		logic [15:0] rate;
	} spd_cfg_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} spd_req_t;

endpackage

// ---- hw/spd_src_sync.sv ----
// Purpose: bring one sibling post-divider clock into the ref_clk domain
// Assumes: source is far slower than ref_clk
// Notes: level moves only once the second and third stages agree
`timescale 1ns/1ps
module spd_src_sync import spd_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// pin and clean level
	input wire logic src_pin,
	output logic level_q
);
`include "spd_defs.svh"

	logic [2:0] stage_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_q <= `SPD_SYNC_RESET;
		end else begin
			stage_q <= {stage_q[1:0], src_pin};
		end
	end

	// stage 0 is read only by stage 1
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= 1'b0;
		end else if (stage_q[1] == stage_q[2]) begin
			level_q <= stage_q[2];
		end
	end

endmodule

// ---- testbench/spd_partner.sv ----
// Purpose: far-side model: sibling clocks, base tick, output meter
// Assumes: one ref_clk domain, every source derived from it
// Notes: run lengths are latched at each change of out_q
`timescale 1ns/1ps
module spd_partner (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// timing sources for the block
	output logic lf_tick,
	output logic [2:0] src_clk_pin,
	// observed output and measured runs
	input wire logic out_q,
	output logic [15:0] hi_len,
	output logic [15:0] lo_len
);
	logic [7:0] tick_q;
	logic [15:0] cnt_q;
	logic last_q;
	// periods 8, 12 and 20 cycles; 120 is their common multiple
	assign src_clk_pin = {(tick_q % 20) < 10, (tick_q % 12) < 6,
		(tick_q % 8) < 4};
	assign lf_tick = (tick_q % 4) == 0;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 8'h00;
			cnt_q <= 16'h0000;
			last_q <= 1'b0;
			hi_len <= 16'h0000;
			lo_len <= 16'h0000;
		end else begin
			tick_q <= (tick_q == 8'h77) ? 8'h00 : tick_q + 8'h01;
			last_q <= out_q;
			if (out_q != last_q) begin
				if (last_q)
					hi_len <= cnt_q;
				else
					lo_len <= cnt_q;
				cnt_q <= 16'h0001;
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end
endmodule

// ---- testbench/synth_post_divider_frame_pulse_tb_top.sv ----
// Purpose: self-checking bench for the channel A post-divider
// Assumes: far side modelled by spd_partner
// Notes: output shape is judged from measured high and low runs
`timescale 1ns/1ps
module synth_post_divider_frame_pulse_tb_top import spd_pkg::*;;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	spd_req_t req = '0;
	logic [7:0] rdata_q;
	logic lf_tick;
	logic out_q;
	logic [2:0] src_clk_pin;
	logic [15:0] hi_len;
	logic [15:0] lo_len;
	logic pin_at_rise;
	int miscompares = 0;
	int samples_checked = 0;
	always #5 ref_clk = ~ref_clk;
	spd_post_div dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req),
		.rdata_q(rdata_q), .lf_tick(lf_tick),
		.src_clk_pin(src_clk_pin), .out_q(out_q));
	spd_partner far_end (.ref_clk(ref_clk), .rst_n(rst_n),
		.lf_tick(lf_tick), .src_clk_pin(src_clk_pin), .out_q(out_q),
		.hi_len(hi_len), .lo_len(lo_len));
	// a pulse start lags its source edge by five cycles, past half of B,
	// so B's pin level then tells which edge started the pulse
	always @(posedge out_q) pin_at_rise <= src_clk_pin[0];
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// all three bytes back to back; a period end between them can still apply a half value
	task automatic write_cfg(input logic [23:0] v);
		for (int i = 0; i < 3; i++) begin
			@(negedge ref_clk);
			req = '{8'h80 + 8'(i), v[23 - 8 * i -: 8], 1'b1, 1'b0};
		end
		@(negedge ref_clk);
		req.wr = 1'b0;
	endtask
	task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge ref_clk);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge ref_clk);
		req.rd = 1'b0;
		@(negedge ref_clk);
		check({16'h0000, rdata_q}, {16'h0000, exp});
	endtask
	// wait covers the old period plus two whole new ones
	task automatic shape(input logic [23:0] v, input int hi, input int lo);
		write_cfg(v);
		repeat (3 * (hi + lo) + 80) @(negedge ref_clk);
		check({8'h00, hi_len}, 24'(hi));
		check({8'h00, lo_len}, 24'(lo));
	endtask
	initial begin
		repeat (12) @(negedge ref_clk);
		rst_n = 1'b1;
		read_chk(8'h80, 8'h00);
		read_chk(8'h82, 8'h02);
		repeat (20) @(negedge ref_clk);
		check({8'h00, hi_len}, 24'h000001);
		check({8'h00, lo_len}, 24'h000001);
		shape(24'h000005, 3, 2);
		shape(24'hf00003, 8, 4);
		shape(24'hf10003, 8, 16);
		check({23'h000000, pin_at_rise}, 24'h000001);
		shape(24'hf20003, 12, 24);
		shape(24'hf30003, 20, 40);
		shape(24'hf50003, 16, 8);
		shape(24'hf90003, 8, 16);
		check({23'h000000, pin_at_rise}, 24'h000000);
		read_chk(8'h80, 8'hf9);
		read_chk(8'h82, 8'h03);
		read_chk(8'h83, 8'h00);
		report_and_stop();
	end
	initial begin
		#200000;
		miscompares++;
		report_and_stop();
	end
endmodule
